// >>> pkg/bpsc_regs.svh
`ifndef BPSC_REGS_SVH
`define BPSC_REGS_SVH

// Power state field codes
`define BPSC_PS_D0          2'h0
`define BPSC_PS_D3HOT       2'h3
// Reset value of the context kept flag: context preserved
`define BPSC_CTX_KEPT_RST   1'b1
// Index of the upstream port
`define BPSC_UP_PORT        0

`endif

// >>> pkg/bpsc_pkg.sv
package bpsc_pkg;

  // Device power states of one bridge
  typedef enum logic [1:0] {
    BPSC_D0_UNINIT,
    BPSC_D0_ACTIVE,
    BPSC_D3_HOT,
    BPSC_D3_COLD
  } bpsc_state_t;

  // Classes of a received TLP as presented to a bridge
  typedef enum logic [2:0] {
    BPSC_TLP_CFG0,
    BPSC_TLP_MSG_SELF,
    BPSC_TLP_REQ_OTHER,
    BPSC_TLP_CPL_SELF,
    BPSC_TLP_CPL_THRU
  } bpsc_tlp_t;

  // Decision for a received TLP
  typedef enum logic [1:0] {
    BPSC_ACT_NORMAL,
    BPSC_ACT_UR,
    BPSC_ACT_UC
  } bpsc_act_t;

endpackage

// >>> pkg/bpsc_port_if.sv
`timescale 1ns/1ps
interface bpsc_port_if;
  import bpsc_pkg::*;
  logic        pm_wr;
  logic [1:0]  pm_wdata;
  logic        configured;
  logic        power_off;
  logic        tlp_valid;
  logic        tlp_secondary;
  bpsc_tlp_t   tlp_class;
  logic        err_valid;
  logic        err_from_tlp;
  bpsc_state_t state;
  logic        l1_req;
  logic        act_valid;
  bpsc_act_t   act;
  logic        err_send;

  modport ctrl (input pm_wr, pm_wdata, configured, power_off, tlp_valid,
                tlp_secondary, tlp_class, err_valid, err_from_tlp,
                output state, l1_req, act_valid, act, err_send);
  modport top  (output pm_wr, pm_wdata, configured, power_off, tlp_valid,
                tlp_secondary, tlp_class, err_valid, err_from_tlp,
                input state, l1_req, act_valid, act, err_send);
endinterface

// >>> core/bpsc_port_pm.sv
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_port_pm
  import bpsc_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  // Per-port controls and decisions
  bpsc_port_if.ctrl   pif
);

  bpsc_state_t next_state;
  bpsc_act_t   next_act;
  logic        in_d3;
  logic        wr_d0;
  logic        wr_d3;

  assign in_d3 = (pif.state == BPSC_D3_HOT);
  assign wr_d0 = pif.pm_wr && (pif.pm_wdata == `BPSC_PS_D0);
  assign wr_d3 = pif.pm_wr && (pif.pm_wdata == `BPSC_PS_D3HOT);

  // Other codes are unsupported and leave the state alone
  always_comb
  begin
    next_state = pif.state;
    case (pif.state)
      BPSC_D0_UNINIT:
        if (wr_d3)
          next_state = BPSC_D3_HOT;
        else if (pif.configured)
          next_state = BPSC_D0_ACTIVE;
      BPSC_D0_ACTIVE:
        if (wr_d3)
          next_state = BPSC_D3_HOT;
      BPSC_D3_HOT:
        if (pif.power_off)
          next_state = BPSC_D3_COLD;
        else if (wr_d0)
          next_state = BPSC_D0_UNINIT;
      BPSC_D3_COLD:
        next_state = BPSC_D3_COLD;
      default:
        next_state = BPSC_D0_UNINIT;
    endcase
  end

  // TLP handling in D3hot; primary side cfg0 and own messages still served
  always_comb
  begin
    next_act = BPSC_ACT_NORMAL;
    if (in_d3)
    begin
      case (pif.tlp_class)
        BPSC_TLP_CFG0,
        BPSC_TLP_MSG_SELF:
          if (pif.tlp_secondary)
            next_act = BPSC_ACT_UR;
          else
            next_act = BPSC_ACT_NORMAL;
        BPSC_TLP_REQ_OTHER:
          next_act = BPSC_ACT_UR;
        BPSC_TLP_CPL_SELF:
          next_act = BPSC_ACT_UC;
        BPSC_TLP_CPL_THRU:
          next_act = BPSC_ACT_NORMAL;
        default:
          next_act = BPSC_ACT_NORMAL;
      endcase
    end
  end

  // No soft reset on D3hot exit: only the state and l1_req move
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pif.state     <= BPSC_D0_UNINIT;
      pif.l1_req    <= 1'b0;
      pif.act_valid <= 1'b0;
      pif.act       <= BPSC_ACT_NORMAL;
      pif.err_send  <= 1'b0;
    end
    else
    begin
      pif.state     <= next_state;
      pif.l1_req    <= (next_state == BPSC_D3_HOT);
      pif.act_valid <= pif.tlp_valid;
      pif.act       <= next_act;
      pif.err_send  <= pif.err_valid &&
                       (!in_d3 || pif.err_from_tlp);
    end
  end

  property p_d3_err_drop;
    @(posedge clk_sys) disable iff (sys_rst)
    (in_d3 && pif.err_valid && !pif.err_from_tlp) |=> !pif.err_send;
  endproperty
  a_d3_err_drop: assert property (p_d3_err_drop)
    else $error("Non-TLP error sent while in D3hot");

  property p_d3_entry;
    @(posedge clk_sys) disable iff (sys_rst)
    (pif.state == BPSC_D0_ACTIVE && wr_d3) |=> in_d3 && pif.l1_req;
  endproperty
  a_d3_entry: assert property (p_d3_entry)
    else $error("Write of D3hot code did not enter D3hot");

  property p_d3_exit;
    @(posedge clk_sys) disable iff (sys_rst)
    (in_d3 && wr_d0 && !pif.power_off) |=>
      pif.state == BPSC_D0_UNINIT && !pif.l1_req;
  endproperty
  a_d3_exit: assert property (p_d3_exit)
    else $error("Write of D0 code did not leave D3hot");

  property p_bad_code;
    @(posedge clk_sys) disable iff (sys_rst)
    (pif.pm_wr && !wr_d0 && !wr_d3 && pif.state != BPSC_D0_UNINIT
     && !pif.power_off) |=> $stable(pif.state);
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("Unsupported code changed the power state");

  property p_cfg0_ok;
    @(posedge clk_sys) disable iff (sys_rst)
    (in_d3 && pif.tlp_valid && !pif.tlp_secondary &&
     pif.tlp_class == BPSC_TLP_CFG0) |=> pif.act == BPSC_ACT_NORMAL;
  endproperty
  a_cfg0_ok: assert property (p_cfg0_ok)
    else $error("Type 0 config refused in D3hot");

  property p_sec_ur;
    @(posedge clk_sys) disable iff (sys_rst)
    (in_d3 && pif.tlp_valid && pif.tlp_secondary &&
     pif.tlp_class inside {BPSC_TLP_CFG0, BPSC_TLP_MSG_SELF,
     BPSC_TLP_REQ_OTHER}) |=> pif.act_valid && pif.act == BPSC_ACT_UR;
  endproperty
  a_sec_ur: assert property (p_sec_ur)
    else $error("Secondary request not UR in D3hot");

  property p_cpl_self;
    @(posedge clk_sys) disable iff (sys_rst)
    (in_d3 && pif.tlp_valid && pif.tlp_class == BPSC_TLP_CPL_SELF)
      |=> pif.act == BPSC_ACT_UC;
  endproperty
  a_cpl_self: assert property (p_cpl_self)
    else $error("Completion to bridge not UC in D3hot");

  property p_cpl_thru;
    @(posedge clk_sys) disable iff (sys_rst)
    (pif.tlp_valid && pif.tlp_class == BPSC_TLP_CPL_THRU)
      |=> pif.act == BPSC_ACT_NORMAL;
  endproperty
  a_cpl_thru: assert property (p_cpl_thru)
    else $error("Pass-through completion not routed");

endmodule

// >>> core/bpsc_lowpower.sv
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_lowpower
  import bpsc_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Upstream state and acknowledge tracking
  input  wire bpsc_state_t          up_state,
  input  wire logic                 turn_off,
  input  wire logic [NUM_PORTS-1:0] ack_rx,
  input  wire logic [NUM_PORTS-1:0] port_active,
  // Result
  output logic                      low_power
);

  logic [NUM_PORTS-1:0] ack_seen;
  logic [NUM_PORTS-1:0] next_ack_seen;
  logic                 all_acked;
  logic                 up_low;

  // Upstream bit and inactive ports count as acknowledged
  assign next_ack_seen = turn_off ? ack_rx : (ack_seen | ack_rx);
  assign all_acked = &(next_ack_seen | ~port_active |
                       NUM_PORTS'(1 << `BPSC_UP_PORT));
  assign up_low = (up_state == BPSC_D3_HOT) || (up_state == BPSC_D3_COLD);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ack_seen  <= '0;
      low_power <= 1'b0;
    end
    else
    begin
      ack_seen  <= next_ack_seen;
      low_power <= up_low && all_acked;
    end
  end

endmodule

// >>> core/bpsc_top.sv
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module bpsc_top
  import bpsc_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // Power state field writes, per port
  input  wire logic [NUM_PORTS-1:0]   pm_wr,
  input  wire logic [NUM_PORTS*2-1:0] pm_wdata,
  input  wire logic [NUM_PORTS-1:0]   configured,
  input  wire logic [NUM_PORTS-1:0]   power_off,
  // Received TLPs, per port
  input  wire logic [NUM_PORTS-1:0]   tlp_valid,
  input  wire logic [NUM_PORTS-1:0]   tlp_secondary,
  input  wire logic [NUM_PORTS*3-1:0] tlp_class,
  // Error events, per port
  input  wire logic [NUM_PORTS-1:0]   err_valid,
  input  wire logic [NUM_PORTS-1:0]   err_from_tlp,
  // Fence protocol
  input  wire logic                   turn_off,
  input  wire logic [NUM_PORTS-1:0]   ack_rx,
  input  wire logic [NUM_PORTS-1:0]   port_active,
  // Results
  output logic [NUM_PORTS*2-1:0]      power_state,
  output logic [NUM_PORTS-1:0]        l1_req,
  output logic [NUM_PORTS-1:0]        act_valid,
  output logic [NUM_PORTS*2-1:0]      act,
  output logic [NUM_PORTS-1:0]        err_send,
  output logic [NUM_PORTS-1:0]        context_kept_flag,
  output logic                        low_power
);

  bpsc_state_t up_state;

  // ----------------------------------------------------------------
  // Per-port controllers, fully independent
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PORTS; i++)
  begin : g_port
    bpsc_port_if pif ();
    assign pif.pm_wr         = pm_wr[i];
    assign pif.pm_wdata      = pm_wdata[i*2 +: 2];
    assign pif.configured    = configured[i];
    assign pif.power_off     = power_off[i];
    assign pif.tlp_valid     = tlp_valid[i];
    assign pif.tlp_secondary = tlp_secondary[i];
    assign pif.tlp_class     = bpsc_tlp_t'(tlp_class[i*3 +: 3]);
    assign pif.err_valid     = err_valid[i];
    assign pif.err_from_tlp  = err_from_tlp[i];

    bpsc_port_pm u_pm (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pif     (pif.ctrl)
    );

    // Outputs come straight from the controller flip-flops
    assign power_state[i*2 +: 2] = pif.state;
    assign l1_req[i]             = pif.l1_req;
    assign act_valid[i]          = pif.act_valid;
    assign act[i*2 +: 2]         = pif.act;
    assign err_send[i]           = pif.err_send;
  end

  // Constant flop: context survives D3hot, nothing clears it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      context_kept_flag <= {NUM_PORTS{`BPSC_CTX_KEPT_RST}};
  end

  assign up_state = bpsc_state_t'(power_state[`BPSC_UP_PORT*2 +: 2]);

  // ----------------------------------------------------------------
  // Device-wide low power from the upstream port
  // ----------------------------------------------------------------
  bpsc_lowpower #(
    .NUM_PORTS (NUM_PORTS)
  ) u_lp (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .up_state    (up_state),
    .turn_off    (turn_off),
    .ack_rx      (ack_rx),
    .port_active (port_active),
    .low_power   (low_power)
  );

  property p_reset_uninit;
    @(posedge clk_sys)
    sys_rst |=> power_state == '0 && l1_req == '0;
  endproperty
  a_reset_uninit: assert property (p_reset_uninit)
    else $error("Reset did not give D0 uninitialized");

  property p_ctx_kept;
    @(posedge clk_sys) disable iff (sys_rst)
    context_kept_flag == {NUM_PORTS{`BPSC_CTX_KEPT_RST}};
  endproperty
  a_ctx_kept: assert property (p_ctx_kept)
    else $error("Context kept flag lost");

  property p_low_needs_up;
    @(posedge clk_sys) disable iff (sys_rst)
    low_power |-> $past(up_state == BPSC_D3_HOT ||
                        up_state == BPSC_D3_COLD);
  endproperty
  a_low_needs_up: assert property (p_low_needs_up)
    else $error("Low power without upstream low state");

endmodule

// >>> testbench/bpsc_link_model.sv
`timescale 1ns/1ps
module bpsc_link_model
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Bench control
  input  wire logic       go,
  input  wire logic [3:0] lag,
  input  wire logic [3:0] active,
  // Fence messages toward the switch
  output logic            turn_off,
  output logic [3:0]      ack_rx
);
  int cnt;

  // -----------------------------------------------
  // Root turn-off, then acks one port per lag step
  // -----------------------------------------------
  // Slow partner: acks never arrive in the same cycle, so the
  // aggregation must wait for the last one
  always @(posedge clk_sys)
  begin
    turn_off <= 1'b0;
    ack_rx   <= '0;
    if (sys_rst)
      cnt <= 0;
    else if (go)
    begin
      turn_off <= 1'b1;
      cnt      <= 1;
    end
    else if (cnt != 0)
    begin
      cnt <= (cnt / lag >= 4) ? 0 : cnt + 1;
      if (cnt % lag == 0 && cnt / lag < 4 && active[cnt / lag])
        ack_rx[cnt / lag] <= 1'b1;
    end
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
`include "bpsc_regs.svh"
module tb;
  import bpsc_pkg::*;
  logic        clk_sys;
  logic        sys_rst;
  logic [3:0]  pm_wr, configured, power_off, tlp_valid, tlp_secondary;
  logic [3:0]  err_valid, err_from_tlp, ack_rx, port_active, l1_req;
  logic [3:0]  act_valid, err_send, context_kept_flag, lag;
  logic [7:0]  pm_wdata, power_state, act;
  logic [11:0] tlp_class;
  logic        turn_off, low_power, go;
  int          n_fail, num_checks, cycles;

  bpsc_top #(.NUM_PORTS(4)) i_bpsc_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pm_wr(pm_wr),
    .pm_wdata(pm_wdata), .configured(configured),
    .power_off(power_off), .tlp_valid(tlp_valid),
    .tlp_secondary(tlp_secondary), .tlp_class(tlp_class),
    .err_valid(err_valid), .err_from_tlp(err_from_tlp),
    .turn_off(turn_off), .ack_rx(ack_rx), .port_active(port_active),
    .power_state(power_state), .l1_req(l1_req),
    .act_valid(act_valid), .act(act), .err_send(err_send),
    .context_kept_flag(context_kept_flag), .low_power(low_power));

  bpsc_link_model i_bpsc_link_model (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .go(go), .lag(lag),
    .active(port_active), .turn_off(turn_off), .ack_rx(ack_rx));

  // -----------------------------------------------
  // Helpers
  // -----------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Idle edge first: back-to-back writes never retoggle pm_wr at once
  task automatic wr(input int p, input logic [1:0] code);
    @(negedge clk_sys);
    pm_wr[p] = 1'b1;
    pm_wdata[2*p+:2] = code;
    @(negedge clk_sys);
    pm_wr = '0;
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // -----------------------------------------------
  // Scenarios
  // -----------------------------------------------
  task automatic t_states();
    configured[1] = 1'b1;
    @(negedge clk_sys);
    chk(power_state, 8'h04);
    configured[1] = 1'b0;
    for (int c = 1; c < 3; c++)
    begin
      wr(1, c[1:0]);
      chk(power_state, 8'h04);
    end
    wr(1, `BPSC_PS_D3HOT);
    chk(power_state, 8'h08);
    chk({4'h0, l1_req}, 8'h02);
    wr(1, `BPSC_PS_D0);
    chk(power_state, 8'h00);
    chk({4'h0, context_kept_flag}, 8'h0F);
  endtask

  // Port 1 stays in D0 uninit as the reference, port 2 in D3hot
  task automatic t_tlp();
    logic [1:0] exp;
    wr(2, `BPSC_PS_D3HOT);
    tlp_valid = 4'h6;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 5; c++)
      begin
        exp = (c == 4) ? 2'h0 : (c == 3) ? 2'h2 :
              (s == 1 || c == 2) ? 2'h1 : 2'h0;
        tlp_secondary = {1'b0, s[0], s[0], 1'b0};
        tlp_class[8:3] = {c[2:0], c[2:0]};
        @(negedge clk_sys);
        chk({4'h0, act_valid}, 8'h06);
        chk(act, {2'h0, exp, 4'h0});
      end
    tlp_valid = '0;
    @(negedge clk_sys);
    chk({4'h0, act_valid}, 8'h00);
  endtask

  task automatic t_err();
    for (int f = 0; f < 2; f++)
    begin
      err_valid = 4'hC;
      err_from_tlp = {4{f[0]}};
      @(negedge clk_sys);
      err_valid = '0;
      chk({4'h0, err_send}, f ? 8'h0C : 8'h08);
      @(negedge clk_sys);
      chk({4'h0, err_send}, 8'h00);
    end
  endtask

  // Power removal beats a D0 write in the same cycle
  task automatic t_cold();
    @(negedge clk_sys);
    power_off[2] = 1'b1;
    pm_wr[2] = 1'b1;
    pm_wdata[5:4] = `BPSC_PS_D0;
    @(negedge clk_sys);
    pm_wr = '0;
    chk(power_state, 8'h30);
    wr(2, `BPSC_PS_D0);
    chk(power_state, 8'h30);
    chk({4'h0, l1_req}, 8'h00);
  endtask

  task automatic t_low();
    wr(0, `BPSC_PS_D3HOT);
    chk({7'h0, low_power}, 8'h00);
    port_active = 4'hE;
    lag = 4'h3;
    go = 1'b1;
    @(negedge clk_sys);
    go = 1'b0;
    for (int i = 0; i < 60 && ack_rx[3] !== 1'b1; i++)
      @(negedge clk_sys);
    chk({7'h0, low_power}, 8'h00);
    @(negedge clk_sys);
    chk({7'h0, low_power}, 8'h01);
  endtask

  // Mid-run reset from D3hot, D3cold and whole-switch low
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(power_state, 8'h00);
    chk({4'h0, l1_req}, 8'h00);
    chk({7'h0, low_power}, 8'h00);
    chk({4'h0, context_kept_flag}, 8'h0F);
    wr(1, `BPSC_PS_D3HOT);
    chk(power_state, 8'h08);
    chk({4'h0, l1_req}, 8'h02);
  endtask

  // -----------------------------------------------
  // Clock, watchdog and main sequence
  // -----------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  initial
  begin
    {pm_wr, pm_wdata, configured, power_off, tlp_valid} = '0;
    {tlp_secondary, tlp_class, err_valid, err_from_tlp} = '0;
    {port_active, go} = '0;
    lag = 4'h1;
    sys_rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk(power_state, 8'h00);
    chk({4'h0, context_kept_flag}, 8'h0F);
    t_states();
    t_tlp();
    t_err();
    t_cold();
    t_low();
    t_reset();
    give_verdict();
  end
endmodule
